/* src/pls_pkg.sv */
// Constants shared by the potential-loss and rotation supervisor.
// Assumes one 40 MHz clock; magnitudes arrive as unsigned numbers on that clock.
package pls_pkg;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [15:0] ALARM_MS_RST = 16'h0032;
  localparam logic [15:0] HOLD_MS_RST  = 16'h0064;
  localparam logic [15:0] LOAD_THR_RST = 16'h03E8;
  // Fractions of rated value, tested as x * DEN < rated
  localparam int unsigned UV_DEN       = 100;
  localparam int unsigned RES_I_DEN    = 10;
  localparam int unsigned DEAD_DEN     = 100;
  localparam int unsigned LIVE_DEN     = 10;
  // Negative/positive ratio above 40 %: v2 * NEG_K2 > v1 * NEG_K1
  localparam int unsigned NEG_K2       = 5;
  localparam int unsigned NEG_K1       = 2;
  // Register byte addresses
  localparam logic [5:0] A_CTRL     = 6'h00;
  localparam logic [5:0] A_LOAD_THR = 6'h04;
  localparam logic [5:0] A_ALARM_MS = 6'h08;
  localparam logic [5:0] A_HOLD_MS  = 6'h0C;
  localparam logic [5:0] A_ELEM_SUP = 6'h10;
  localparam logic [5:0] A_TRIG_MSK = 6'h14;
  localparam logic [5:0] A_STATUS   = 6'h18;
  localparam logic [5:0] A_IRQ_STAT = 6'h1C;
  localparam logic [5:0] A_IRQ_MASK = 6'h20;
  // Control fields
  localparam int unsigned C_PROP_EN  = 0;
  localparam int unsigned C_BRK_ASGN = 1;
  localparam int unsigned C_DEAD_EN  = 2;
  localparam int unsigned C_ROT      = 3;
  localparam int unsigned C_CT_SEL   = 4;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0005;
  // Live status fields
  localparam int unsigned S_COND  = 0;
  localparam int unsigned S_BLOCK = 1;
  localparam int unsigned S_FUSE  = 2;
  localparam int unsigned S_WARN  = 8;
  // Interrupt status fields
  localparam int unsigned I_BLOCK = 0;
  localparam int unsigned I_FUSE  = 1;
  localparam int unsigned I_WARN  = 2;
  localparam int unsigned I_BITS  = 3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_BLOCK = 2'b10,
    ST_HOLD  = 2'b11
  } sup_state_t;

  typedef enum logic {
    ROT_ABC = 1'b0,
    ROT_ACB = 1'b1
  } rot_t;
endpackage

/* src/rot_if.sv */
// Carrier between the supervisor and its rotation checker.
// Channel 0 is the voltage input, channels 1..N-1 the current inputs.
`timescale 1ns/100ps
interface rot_if #(parameter int N = 3, parameter int W = 16);
  logic [N-1:0][W-1:0] pos;
  logic [N-1:0][W-1:0] neg;
  logic [N-1:0]        live;
  logic                setting;
  // A net, so each checker channel may drive its own bit
  wire logic [N-1:0]   warn;
  modport src (output pos, output neg, output live, output setting, input warn);
  modport chk (input pos, input neg, input live, input setting, output warn);
endinterface

/* src/rot_checker.sv */
// Per-input phase rotation check against the configured order.
// Assumes sequence magnitudes are stable on i_sys_clk.
`timescale 1ns/100ps
module rot_checker
  import pls_pkg::*;
#(
  parameter int N = 3
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  rot_if.chk        rif
);
  for (genvar c = 0; c < N; c++) begin : g_ch
    rot_t rot;
    logic warn_q;
    // Negative sequence dominating means the opposite order
    assign rot = (rif.neg[c] > rif.pos[c]) ? ROT_ACB : ROT_ABC;
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
        warn_q <= 1'b0;
      end else begin
        warn_q <= rif.live[c] && (rot != rot_t'(rif.setting));
      end
    end
    assign rif.warn[c] = warn_q;

    a_warn_on_diff : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      rif.live[c] && (rot != rot_t'(rif.setting)) |=> rif.warn[c])
      else $error("rotation mismatch not flagged");
    a_warn_needs_live : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !rif.live[c] |=> !rif.warn[c])
      else $error("rotation warning below minimum level");
  end
endmodule

/* src/potential_loss_supervisor.sv */
// Potential-loss blocking and phase rotation supervisor with Avalon-MM registers.
// Assumes measured magnitudes and pickups are synchronous to i_sys_clk;
// the fuse-fail and breaker pins are asynchronous.
`timescale 1ns/100ps
module potential_loss_supervisor
  import pls_pkg::*;
#(
  parameter int          NCT      = 2,
  parameter int          NELEM    = 8,
  parameter int          NTRIG    = 8,
  parameter logic [15:0] V_RATED  = 16'h2710,
  parameter logic [15:0] I_RATED  = 16'h2710,
  parameter int unsigned TICK_CYC_P = TICK_CYC
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  input  wire logic [5:0]                    i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [31:0]                   i_avs_writedata,
  input  wire logic [3:0]                    i_avs_byteenable,
  output logic      [31:0]                   o_avs_readdata,
  output logic                               o_avs_waitrequest,
  input  wire logic [2:0][15:0]              i_vt_phase_mag,
  input  wire logic [15:0]                   i_vt_res_mag,
  input  wire logic [15:0]                   i_vt_pos_mag,
  input  wire logic [15:0]                   i_vt_neg_mag,
  input  wire logic [NCT-1:0][2:0][15:0]     i_ct_phase_mag,
  input  wire logic [NCT-1:0][15:0]          i_ct_res_mag,
  input  wire logic [NCT-1:0][15:0]          i_ct_pos_mag,
  input  wire logic [NCT-1:0][15:0]          i_ct_neg_mag,
  input  wire logic [NTRIG-1:0]              i_oc_pickup,
  input  wire logic                          i_fuse_fail_input,
  input  wire logic                          i_breaker_closed,
  output logic                               o_potential_loss_block,
  output logic      [NELEM-1:0]              o_elem_block,
  output logic      [NCT:0]                  o_rot_warn,
  output logic                               o_irq
);
  localparam int CSW = (NCT > 1) ? $clog2(NCT) : 1;

  function automatic logic lt_frac(input logic [15:0] x, input int unsigned den,
                                   input logic [15:0] r);
    return (64'(x) * 64'(den)) < 64'(r);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  logic [31:0]       ctrl_q;
  logic [15:0]       load_thr_q;
  logic [15:0]       alarm_ms_q;
  logic [15:0]       hold_ms_q;
  logic [NELEM-1:0]  elem_sup_q;
  logic [NTRIG-1:0]  trig_msk_q;
  logic [I_BITS-1:0] irq_stat_q;
  logic [I_BITS-1:0] irq_mask_q;
  logic              ack_q;
  logic              req;
  logic              wr_acc;
  logic              rd_acc;
  logic [31:0]       rdata_d;

  // Bus slave: every access waits exactly one cycle
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_acc            = i_avs_write & ack_q;
  assign rd_acc            = i_avs_read & ack_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_q;
  logic       fuse;
  logic       brk_closed;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q    <= 2'h0;
    end else begin
      pin_s1_q <= {i_breaker_closed, i_fuse_fail_input};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int k = 0; k < 2; k++) begin
        if (pin_s2_q[k] == pin_s3_q[k]) begin
          pin_q[k] <= pin_s2_q[k];
        end
      end
    end
  end
  assign fuse       = pin_q[0];
  assign brk_closed = pin_q[1];

  // Condition evaluation
  logic [CSW-1:0] ct_idx;
  logic           uv_any;
  logic           vres_ok;
  logic           i_low;
  logic           ires_low;
  logic           pick;
  logic           brk_ok;
  logic           dead;
  logic           dead_ok;
  logic           core;
  logic           cond_q;

  always_comb begin
    ct_idx = ctrl_q[C_CT_SEL +: CSW];
    if (32'(ct_idx) >= NCT) begin
      ct_idx = '0;
    end
  end

  always_comb begin
    uv_any  = 1'b0;
    i_low   = 1'b1;
    for (int p = 0; p < 3; p++) begin
      uv_any = uv_any | lt_frac(i_vt_phase_mag[p], UV_DEN, V_RATED);
      i_low  = i_low & (i_ct_phase_mag[ct_idx][p] < load_thr_q);
    end
    vres_ok  = lt_frac(i_vt_res_mag, UV_DEN, V_RATED)
             | (64'(i_vt_neg_mag) * 64'(NEG_K2) > 64'(i_vt_pos_mag) * 64'(NEG_K1));
    ires_low = lt_frac(i_ct_res_mag[ct_idx], RES_I_DEN, I_RATED);
    pick     = |(i_oc_pickup & trig_msk_q);
    brk_ok   = !ctrl_q[C_BRK_ASGN] || brk_closed;
    dead     = lt_frac(i_vt_pos_mag, DEAD_DEN, V_RATED)
             & lt_frac(i_ct_pos_mag[ct_idx], DEAD_DEN, I_RATED);
    dead_ok  = !ctrl_q[C_DEAD_EN] || !dead;
    core     = uv_any & vres_ok & i_low & ires_low & ~pick & dead_ok;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= core & brk_ok;
    end
  end

  // Millisecond tick
  logic [31:0] tick_cnt_q;
  logic        ms_tick;
  assign ms_tick = (tick_cnt_q == 32'(TICK_CYC_P - 1));
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= ms_tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // Pickup delay and release hold
  sup_state_t  state_q;
  logic [15:0] ms_cnt_q;
  logic [15:0] ms_nxt;
  logic        blk;
  assign ms_nxt = ms_cnt_q + 16'h1;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q  <= ST_IDLE;
      ms_cnt_q <= 16'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ms_cnt_q <= 16'h0;
          if (cond_q) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (!cond_q) begin
            state_q <= ST_IDLE;
          end else if (ms_cnt_q >= alarm_ms_q) begin
            state_q  <= ST_BLOCK;
            ms_cnt_q <= 16'h0;
          end else if (ms_tick) begin
            ms_cnt_q <= ms_nxt;
          end
        end
        ST_BLOCK: begin
          ms_cnt_q <= 16'h0;
          if (!cond_q) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cond_q) begin
            state_q  <= ST_BLOCK;
            ms_cnt_q <= 16'h0;
          end else if (ms_cnt_q >= hold_ms_q) begin
            state_q <= ST_IDLE;
          end else if (ms_tick) begin
            ms_cnt_q <= ms_nxt;
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          ms_cnt_q <= 16'h0;
        end
      endcase
    end
  end
  assign blk = (state_q == ST_BLOCK) || (state_q == ST_HOLD);

  // Element blocking; the fuse path bypasses the propagation enable
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_potential_loss_block <= 1'b0;
      o_elem_block           <= '0;
    end else begin
      o_potential_loss_block <= blk;
      o_elem_block <= elem_sup_q & {NELEM{(blk & ctrl_q[C_PROP_EN]) | fuse}};
    end
  end

  // Rotation supervision
  rot_if #(.N(NCT + 1), .W(16)) rif ();
  always_comb begin
    rif.pos[0]  = i_vt_pos_mag;
    rif.neg[0]  = i_vt_neg_mag;
    rif.live[0] = !lt_frac(i_vt_pos_mag, LIVE_DEN, V_RATED);
    for (int c = 0; c < NCT; c++) begin
      rif.pos[c+1]  = i_ct_pos_mag[c];
      rif.neg[c+1]  = i_ct_neg_mag[c];
      rif.live[c+1] = !lt_frac(i_ct_pos_mag[c], LIVE_DEN, I_RATED);
    end
    rif.setting = ctrl_q[C_ROT];
  end
  rot_checker #(.N(NCT + 1)) u_rot (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .rif       (rif)
  );
  assign o_rot_warn = rif.warn;

  // Interrupt events; a new event beats the clearing read
  logic             blk_d1_q;
  logic             fuse_d1_q;
  logic             warn_d1_q;
  logic [I_BITS-1:0] ev;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      blk_d1_q  <= 1'b0;
      fuse_d1_q <= 1'b0;
      warn_d1_q <= 1'b0;
    end else begin
      blk_d1_q  <= blk;
      fuse_d1_q <= fuse;
      warn_d1_q <= |rif.warn;
    end
  end
  assign ev[I_BLOCK] = blk & ~blk_d1_q;
  assign ev[I_FUSE]  = fuse ^ fuse_d1_q;
  assign ev[I_WARN]  = (|rif.warn) & ~warn_d1_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_stat_q <= '0;
    end else if (rd_acc && i_avs_address == A_IRQ_STAT) begin
      // Only bits that the read returned are cleared, so none is lost
      irq_stat_q <= (irq_stat_q & ~o_avs_readdata[I_BITS-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Register writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_q     <= CTRL_RST;
      load_thr_q <= LOAD_THR_RST;
      alarm_ms_q <= ALARM_MS_RST;
      hold_ms_q  <= HOLD_MS_RST;
      elem_sup_q <= '0;
      trig_msk_q <= '0;
      irq_mask_q <= '0;
    end else if (wr_acc) begin
      case (i_avs_address)
        A_CTRL:     ctrl_q     <= merge(ctrl_q, i_avs_writedata, i_avs_byteenable);
        A_LOAD_THR: load_thr_q <= 16'(merge(32'(load_thr_q), i_avs_writedata,
                                            i_avs_byteenable));
        A_ALARM_MS: alarm_ms_q <= 16'(merge(32'(alarm_ms_q), i_avs_writedata,
                                            i_avs_byteenable));
        A_HOLD_MS:  hold_ms_q  <= 16'(merge(32'(hold_ms_q), i_avs_writedata,
                                            i_avs_byteenable));
        A_ELEM_SUP: elem_sup_q <= NELEM'(merge(32'(elem_sup_q), i_avs_writedata,
                                               i_avs_byteenable));
        A_TRIG_MSK: trig_msk_q <= NTRIG'(merge(32'(trig_msk_q), i_avs_writedata,
                                               i_avs_byteenable));
        A_IRQ_MASK: irq_mask_q <= I_BITS'(merge(32'(irq_mask_q), i_avs_writedata,
                                                i_avs_byteenable));
        default: ;
      endcase
    end
  end

  // Register reads, captured in the waiting cycle
  always_comb begin
    rdata_d = 32'h0;
    case (i_avs_address)
      A_CTRL:     rdata_d = ctrl_q;
      A_LOAD_THR: rdata_d = 32'(load_thr_q);
      A_ALARM_MS: rdata_d = 32'(alarm_ms_q);
      A_HOLD_MS:  rdata_d = 32'(hold_ms_q);
      A_ELEM_SUP: rdata_d = 32'(elem_sup_q);
      A_TRIG_MSK: rdata_d = 32'(trig_msk_q);
      A_STATUS: begin
        rdata_d[S_COND]             = cond_q;
        rdata_d[S_BLOCK]            = blk;
        rdata_d[S_FUSE]             = fuse;
        rdata_d[S_WARN +: NCT + 1]  = rif.warn;
      end
      A_IRQ_STAT: rdata_d = 32'(irq_stat_q);
      A_IRQ_MASK: rdata_d = 32'(irq_mask_q);
      default:    rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= rdata_d;
    end
  end

  // Checks
  a_block_needs_cond : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(blk) |-> $past(cond_q))
    else $error("block raised without conditions");
  a_no_uv_no_cond : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !uv_any |=> !cond_q)
    else $error("condition without undervoltage");
  a_vres_gate : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !vres_ok |=> !cond_q)
    else $error("condition with residual voltage present");
  a_load_gate : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(i_low && ires_low) |=> !cond_q)
    else $error("condition with load current present");
  a_pickup_gate : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    pick |=> !cond_q)
    else $error("condition during assigned pickup");
  a_brk_closed : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ctrl_q[C_BRK_ASGN] && !brk_closed |=> !cond_q)
    else $error("condition with breaker open");
  a_brk_ignored : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ctrl_q[C_BRK_ASGN] && core |=> cond_q)
    else $error("unassigned breaker affected condition");
  a_dead_bus : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ctrl_q[C_DEAD_EN] && dead |=> !cond_q)
    else $error("condition on dead bus");
  a_elem_block : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (blk && ctrl_q[C_PROP_EN]) || fuse |=> o_elem_block == $past(elem_sup_q))
    else $error("supervised element not blocked");
  a_no_prop : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !ctrl_q[C_PROP_EN] && !fuse |=> o_elem_block == '0)
    else $error("blocking propagated while disabled");
  a_hold_release : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_q == ST_HOLD && !cond_q && ms_cnt_q < hold_ms_q |=> blk)
    else $error("block released before hold time");
  a_delay_wait : assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_q == ST_DELAY && ms_cnt_q < alarm_ms_q |=> !blk)
    else $error("block raised before alarm delay");

  c_block : cover property (@(posedge i_sys_clk) $rose(blk));
  c_rehit : cover property (@(posedge i_sys_clk) state_q == ST_HOLD ##1 state_q == ST_BLOCK);
  c_fuse  : cover property (@(posedge i_sys_clk) $rose(fuse));
  c_warn  : cover property (@(posedge i_sys_clk) $rose(|rif.warn));
endmodule

/* testbench/meas_front_end.sv */
// Model of the measurement front end that feeds the supervisor.
// Assumes the bench changes i_mode just after a rising clock edge.
`timescale 1ns/100ps
module meas_front_end (
  input  wire logic [3:0]            i_mode,
  output logic      [2:0][15:0]      o_vph,
  output logic      [15:0]           o_vres,
  output logic      [15:0]           o_vpos,
  output logic      [15:0]           o_vneg,
  output logic      [1:0][2:0][15:0] o_iph,
  output logic      [1:0][15:0]      o_ires,
  output logic      [1:0][15:0]      o_ipos,
  output logic      [1:0][15:0]      o_ineg
);
  // Mode 0 is a lost phase on a lightly loaded, healthy feeder
  always_comb begin
    o_vph  = {16'h2710, 16'h2710, 16'h0000};
    o_vres = 16'h0000;
    o_vpos = 16'h1770;
    o_vneg = 16'h0064;
    o_iph  = {6{16'h01F4}};
    o_ires = {2{16'h0000}};
    o_ipos = {2{16'h01F4}};
    o_ineg = {2{16'h0000}};
    case (i_mode)
      4'h1: o_vph[0] = 16'h2710;
      4'h2: o_vres = 16'h07D0;
      4'h3: begin
        o_vres = 16'h07D0;
        o_vneg = 16'h0BB8;
      end
      4'h4: o_iph[0][1] = 16'h07D0;
      // Exactly one tenth of rated current counts as not below
      4'h5: o_ires[0] = 16'h03E8;
      4'h6: begin
        o_vpos    = 16'h0000;
        o_ipos[0] = 16'h0000;
      end
      4'h7: o_iph[0] = {3{16'h07D0}};
      4'h8: begin
        o_vph  = {3{16'h2710}};
        o_vneg = 16'h2710;
      end
      4'h9: begin
        o_vph  = {3{16'h2710}};
        o_vpos = 16'h0320;
        o_vneg = 16'h2710;
      end
      4'hA: begin
        o_ipos[1] = 16'h03E8;
        o_ineg[1] = 16'h07D0;
      end
      default: ;
    endcase
  end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the potential-loss and rotation supervisor.
// Assumes the front end model drives all magnitudes; a ms tick is 4 cycles.
`timescale 1ns/100ps
module testbench;
  import pls_pkg::*;
  localparam int unsigned TK = 4;
  logic                  i_sys_clk;
  logic                  i_rst_n;
  logic [5:0]            adr;
  logic                  rd_en;
  logic                  wr_en;
  logic [31:0]           wdat;
  logic [3:0]            be;
  logic [31:0]           rdat;
  logic                  wreq;
  logic [3:0]            mode;
  logic [7:0]            pick;
  logic                  fuse;
  logic                  brk;
  logic                  blk;
  logic [7:0]            eblk;
  logic [2:0]            warn;
  logic                  irq;
  logic [2:0][15:0]      vph;
  logic [15:0]           vres;
  logic [15:0]           vpos;
  logic [15:0]           vneg;
  logic [1:0][2:0][15:0] iph;
  logic [1:0][15:0]      ires;
  logic [1:0][15:0]      ipos;
  logic [1:0][15:0]      ineg;
  int                    mismatches;
  int                    n_compared;

  meas_front_end u_fe (.i_mode(mode), .o_vph(vph), .o_vres(vres), .o_vpos(vpos),
    .o_vneg(vneg), .o_iph(iph), .o_ires(ires), .o_ipos(ipos), .o_ineg(ineg));

  potential_loss_supervisor #(.TICK_CYC_P(TK)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_vt_phase_mag(vph), .i_vt_res_mag(vres), .i_vt_pos_mag(vpos),
    .i_vt_neg_mag(vneg), .i_ct_phase_mag(iph), .i_ct_res_mag(ires),
    .i_ct_pos_mag(ipos), .i_ct_neg_mag(ineg), .i_oc_pickup(pick),
    .i_fuse_fail_input(fuse), .i_breaker_closed(brk),
    .o_potential_loss_block(blk), .o_elem_block(eblk), .o_rot_warn(warn),
    .o_irq(irq));

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge at which waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    adr   <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat  <= d;
    be    <= b;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic wait_blk(input logic e, output int n);
    n = 0;
    while (blk !== e && n < 200) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, A_CTRL, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0005);
    bus(1'b0, A_LOAD_THR, 32'h0, 4'hF, q);
    chk(q, 32'h0000_03E8);
    bus(1'b0, A_ALARM_MS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0032);
    bus(1'b0, A_HOLD_MS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0064);
    bus(1'b1, A_LOAD_THR, 32'h0000_FFFF, 4'h1, q);
    bus(1'b0, A_LOAD_THR, 32'h0, 4'hF, q);
    chk(q, 32'h0000_03FF);
    wr(6'h24, 32'hFFFF_FFFF);
    bus(1'b0, 6'h24, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0000);
    wr(A_LOAD_THR, 32'h0000_03E8);
    $display("test regs done");
  endtask

  task automatic t_block();
    int n;
    wr(A_ALARM_MS, 32'h2);
    wr(A_HOLD_MS, 32'h3);
    wr(A_ELEM_SUP, 32'hA5);
    wr(A_TRIG_MSK, 32'h1);
    wr(A_CTRL, 32'h7);
    mode <= 4'h0;
    wait_blk(1'b1, n);
    chk(n >= 2 * TK && n <= 3 * TK + 8, 1);
    repeat (2) @(posedge i_sys_clk);
    chk(eblk, 32'hA5);
    mode <= 4'h1;
    wait_blk(1'b0, n);
    chk(n >= 3 * TK && n <= 4 * TK + 8, 1);
    repeat (2) @(posedge i_sys_clk);
    chk(eblk, 0);
    wr(A_CTRL, 32'h6);
    mode <= 4'h0;
    wait_blk(1'b1, n);
    repeat (2) @(posedge i_sys_clk);
    chk(eblk, 0);
    mode <= 4'h1;
    wait_blk(1'b0, n);
    $display("test block done");
  endtask

  task automatic try_case(input logic [31:0] c, input logic [3:0] m, input logic b,
                          input logic [7:0] p, input logic e);
    wr(A_CTRL, c);
    mode <= m;
    brk  <= b;
    pick <= p;
    repeat (40) @(posedge i_sys_clk);
    chk(blk, e);
    mode <= 4'h1;
    brk  <= 1'b1;
    pick <= 8'h00;
    repeat (40) @(posedge i_sys_clk);
  endtask

  task automatic t_conds();
    try_case(32'h7, 4'h1, 1'b1, 8'h00, 1'b0);
    try_case(32'h7, 4'h2, 1'b1, 8'h00, 1'b0);
    try_case(32'h7, 4'h3, 1'b1, 8'h00, 1'b1);
    try_case(32'h7, 4'h4, 1'b1, 8'h00, 1'b0);
    try_case(32'h7, 4'h5, 1'b1, 8'h00, 1'b0);
    try_case(32'h7, 4'h0, 1'b1, 8'h01, 1'b0);
    try_case(32'h7, 4'h0, 1'b1, 8'h02, 1'b1);
    try_case(32'h7, 4'h0, 1'b0, 8'h00, 1'b0);
    try_case(32'h5, 4'h0, 1'b0, 8'h00, 1'b1);
    try_case(32'h7, 4'h6, 1'b1, 8'h00, 1'b0);
    try_case(32'h3, 4'h6, 1'b1, 8'h00, 1'b1);
    try_case(32'h7, 4'h7, 1'b1, 8'h00, 1'b0);
    try_case(32'h17, 4'h7, 1'b1, 8'h00, 1'b1);
    $display("test conditions done");
  endtask

  task automatic t_fuse();
    logic [31:0] q;
    wr(A_CTRL, 32'h6);
    wr(A_IRQ_MASK, 32'h2);
    bus(1'b0, A_IRQ_STAT, 32'h0, 4'hF, q);
    fuse <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    chk(eblk, 32'hA5);
    chk(irq, 1);
    bus(1'b0, A_IRQ_STAT, 32'h0, 4'hF, q);
    chk(q & 32'h2, 32'h2);
    bus(1'b0, A_IRQ_STAT, 32'h0, 4'hF, q);
    chk(q & 32'h2, 0);
    wr(A_IRQ_MASK, 32'h0);
    fuse <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    chk(irq, 0);
    wr(A_IRQ_MASK, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    chk(irq, 1);
    bus(1'b0, A_IRQ_STAT, 32'h0, 4'hF, q);
    repeat (2) @(posedge i_sys_clk);
    chk(irq, 0);
    $display("test fuse done");
  endtask

  task automatic rot_case(input logic [31:0] c, input logic [3:0] m, input logic [2:0] e);
    wr(A_CTRL, c);
    mode <= m;
    repeat (6) @(posedge i_sys_clk);
    chk(warn, e);
  endtask

  initial begin
    i_rst_n    = 1'b0;
    adr        = 6'h00;
    rd_en      = 1'b0;
    wr_en      = 1'b0;
    wdat       = 32'h0;
    be         = 4'hF;
    mode       = 4'h1;
    pick       = 8'h00;
    fuse       = 1'b0;
    brk        = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_block();
    t_conds();
    t_fuse();
    rot_case(32'h7, 4'h8, 3'b001);
    rot_case(32'h7, 4'h9, 3'b000);
    rot_case(32'h7, 4'hA, 3'b100);
    rot_case(32'hF, 4'h8, 3'b000);
    rot_case(32'hF, 4'h1, 3'b001);
    $display("test rotation done");
    summarize();
  end
endmodule
